// ===== shared/ctc_pkg.sv
// Package for the clock tree configuration block
package ctc_pkg;
   localparam logic [7:0] CTC_CFG_ADDR = 8'h04;
   localparam logic [7:0] CTC_CTRL_ADDR = 8'h00;
   localparam logic [31:0] CTC_CFG_RESET = 32'h2000_0000;
   localparam int CTC_CODIV_HI = 31;
   localparam int CTC_CODIV_LO = 28;
   localparam int CTC_COSEL_HI = 27;
   localparam int CTC_COSEL_LO = 25;
   localparam int CTC_LSRC_BIT = 24;
   localparam int CTC_LODIV_HI = 23;
   localparam int CTC_LODIV_LO = 22;
   localparam int CTC_LPRE_HI = 21;
   localparam int CTC_LPRE_LO = 20;
   localparam int CTC_LMUL_HI = 19;
   localparam int CTC_LMUL_LO = 16;
   localparam int CTC_STSH_HI = 15;
   localparam int CTC_STSH_LO = 14;
   localparam int CTC_FPP_HI = 13;
   localparam int CTC_FPP_LO = 11;
   localparam int CTC_SPP_HI = 10;
   localparam int CTC_SPP_LO = 8;
   localparam int CTC_MBP_HI = 7;
   localparam int CTC_MBP_LO = 4;
   localparam int CTC_STSL_BIT = 3;
   localparam int CTC_SW_HI = 2;
   localparam int CTC_SW_LO = 0;
   localparam int CTC_LOOP_EN_BIT = 0;
   localparam logic [31:0] CTC_SW_MASK = 32'h0000_0007;
   localparam logic [3:0] CTC_CODIV_MIN = 4'h2;
   localparam logic [4:0] CTC_LMUL_OFFSET = 5'h03;
   localparam logic [2:0] CTC_SRC_FINT = 3'h0;
   localparam logic [2:0] CTC_SRC_FEXT = 3'h1;
   localparam logic [2:0] CTC_SRC_LOOP = 3'h2;
   localparam logic [2:0] CTC_SRC_SEXT = 3'h3;
   localparam logic [2:0] CTC_SRC_SINT = 3'h4;
   localparam logic [2:0] CTC_CO_NONE = 3'h0;
   localparam logic [2:0] CTC_CO_SINT = 3'h1;
   localparam logic [2:0] CTC_CO_SEXT = 3'h2;
   localparam logic [2:0] CTC_CO_SYS = 3'h3;
   localparam logic [2:0] CTC_CO_FINT = 3'h4;
   localparam logic [2:0] CTC_CO_FEXT = 3'h5;
   localparam logic [2:0] CTC_CO_LOOP = 3'h6;
   // Clock sources as one-cycle enables of mclk
   typedef struct packed {
      logic slow_internal_osc;
      logic slow_external_osc;
      logic fast_internal_osc;
      logic fast_external_osc;
      logic loop;
   } ctc_src_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ctc_bus_t;
endpackage : ctc_pkg

// ===== verilog/ctc_clock_config.sv
// Clock tree configuration register and enable-based dividers
// Behaviour
// - Clock output divider bits 31:28 divide loop clock by code, 2 to 15.
// - Clock output selector 27:25 picks none, slow/fast osc, system or loop.
// - Clock output may give a short pulse at start or source change.
// - Loop source bit 24 picks fast internal (0) or fast external (1).
// - Loop source writes are ignored while the loop runs.
// - Loop output divider 23:22 divides by 1, 2, 3 or 4.
// - Loop input prescaler 21:20 divides input by field plus one.
// - Loop multiplier factor is field plus 3, range 3 to 18.
// - Loop multiplier writes are ignored while the loop runs.
// - Two status bits plus one status bit form three-bit source code.
// - Fast peripheral prescaler: 0xx undivided, 100-111 divide 2 to 16.
// - Slow peripheral prescaler uses the same encoding as the fast one.
// - Main bus prescaler: 0xxx undivided, 1000-1011 divide 2 to 16.
// - Configuration word resets to 0x2000_0000.
// - Status code 000 fast int, 001 fast ext, 010 loop, 011/100 slow.
// - Switch field forced to fast internal on stop exit, or on failure while clock security is enabled.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module ctc_clock_config (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire ctc_pkg::ctc_bus_t bus,
   output logic [31:0] rdata,
   input wire ctc_pkg::ctc_src_t src,
   input wire logic [2:0] active_source,
   input wire logic stop_exit,
   input wire logic fast_ext_fail,
   input wire logic clock_security_enable,
   output logic [2:0] system_clock_switch,
   output logic loop_source_sel,
   output logic [4:0] loop_multiplier,
   output logic [1:0] loop_input_prescaler,
   output logic loop_in_en,
   output logic loop_out_en,
   output logic clkout_en,
   output logic main_bus_en,
   output logic fast_periph_en,
   output logic slow_periph_en
);
   logic [31:0] cfg_q;
   logic loop_on_q;
   logic [2:0] sts_q;
   logic [3:0] co_cnt_q;
   logic [3:0] co_lim;
   logic [1:0] lo_cnt_q;
   logic [1:0] pre_cnt_q;
   logic [3:0] mb_cnt_q;
   logic [3:0] pp_cnt_q [2];
   logic co_src;
   logic lpre_in;
   logic lo_tick;
   logic mb_tick;
   logic [3:0] mb_lim;
   logic [3:0] pp_lim [2];
   logic pp_tick [2];
   logic wr_cfg;
   logic wr_ctrl;
   logic [31:0] wmask;

   assign wr_cfg = bus.wr && (bus.addr == ctc_pkg::CTC_CFG_ADDR);
   assign wr_ctrl = bus.wr && (bus.addr == ctc_pkg::CTC_CTRL_ADDR);

   // Status bits are read-only; loop source and multiplier fields are frozen while loop runs
   always_comb begin
      wmask = 32'hffff_ffff;
      wmask[ctc_pkg::CTC_STSH_HI:ctc_pkg::CTC_STSH_LO] = 2'h0;
      wmask[ctc_pkg::CTC_STSL_BIT] = 1'b0;
      if (loop_on_q) begin
         wmask[ctc_pkg::CTC_LSRC_BIT] = 1'b0;
         wmask[ctc_pkg::CTC_LMUL_HI:ctc_pkg::CTC_LMUL_LO] = 4'h0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfg_q <= ctc_pkg::CTC_CFG_RESET;
      end else begin
         if (wr_cfg) begin
            cfg_q <= (cfg_q & ~wmask) | (bus.wdata & wmask);
         end
         // Hardware force beats a same-cycle software write
         if (stop_exit || (fast_ext_fail && clock_security_enable)) begin
            cfg_q[ctc_pkg::CTC_SW_HI:ctc_pkg::CTC_SW_LO] <=
               ctc_pkg::CTC_SRC_FINT;
         end
      end
   end

   // Minimal loop enable so the write lock has something to watch
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         loop_on_q <= 1'b0;
      end else if (wr_ctrl) begin
         loop_on_q <= bus.wdata[ctc_pkg::CTC_LOOP_EN_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sts_q <= ctc_pkg::CTC_SRC_FINT;
      end else begin
         sts_q <= active_source;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdata <= 32'h0000_0000;
      end else if (bus.rd) begin
         if (bus.addr == ctc_pkg::CTC_CFG_ADDR) begin
            rdata <= cfg_q;
            rdata[ctc_pkg::CTC_STSH_HI:ctc_pkg::CTC_STSH_LO] <=
               sts_q[2:1];
            rdata[ctc_pkg::CTC_STSL_BIT] <= sts_q[0];
         end else if (bus.addr == ctc_pkg::CTC_CTRL_ADDR) begin
            rdata <= {31'h0, loop_on_q};
         end else begin
            rdata <= 32'h0000_0000;
         end
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   // Loop input prescaler, counts selected oscillator ticks
   assign lpre_in = cfg_q[ctc_pkg::CTC_LSRC_BIT] ?
      src.fast_external_osc : src.fast_internal_osc;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pre_cnt_q <= 2'h0;
         loop_in_en <= 1'b0;
      end else begin
         loop_in_en <= 1'b0;
         if (lpre_in) begin
            // Terminal compare with >= so a smaller new limit never stalls
            if (pre_cnt_q >= cfg_q[ctc_pkg::CTC_LPRE_HI:ctc_pkg::CTC_LPRE_LO])
            begin
               pre_cnt_q <= 2'h0;
               loop_in_en <= 1'b1;
            end else begin
               pre_cnt_q <= pre_cnt_q + 2'h1;
            end
         end
      end
   end

   // Loop output divider on loop ticks
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         lo_cnt_q <= 2'h0;
      end else if (src.loop) begin
         if (lo_cnt_q >= cfg_q[ctc_pkg::CTC_LODIV_HI:ctc_pkg::CTC_LODIV_LO])
         begin
            lo_cnt_q <= 2'h0;
         end else begin
            lo_cnt_q <= lo_cnt_q + 2'h1;
         end
      end
   end
   assign lo_tick = src.loop && (lo_cnt_q >=
      cfg_q[ctc_pkg::CTC_LODIV_HI:ctc_pkg::CTC_LODIV_LO]);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         loop_out_en <= 1'b0;
      end else begin
         loop_out_en <= lo_tick;
      end
   end

   // Clock output selection
   always_comb begin
      case (cfg_q[ctc_pkg::CTC_COSEL_HI:ctc_pkg::CTC_COSEL_LO])
         ctc_pkg::CTC_CO_SINT: co_src = src.slow_internal_osc;
         ctc_pkg::CTC_CO_SEXT: co_src = src.slow_external_osc;
         ctc_pkg::CTC_CO_SYS: co_src = 1'b1;
         ctc_pkg::CTC_CO_FINT: co_src = src.fast_internal_osc;
         ctc_pkg::CTC_CO_FEXT: co_src = src.fast_external_osc;
         ctc_pkg::CTC_CO_LOOP: co_src = src.loop;
         default: co_src = 1'b0;
      endcase
   end

   // Divider applies to the loop source only; codes below 2 act as 2
   always_comb begin
      co_lim = 4'h0;
      if (cfg_q[ctc_pkg::CTC_COSEL_HI:ctc_pkg::CTC_COSEL_LO] ==
          ctc_pkg::CTC_CO_LOOP) begin
         if (cfg_q[ctc_pkg::CTC_CODIV_HI:ctc_pkg::CTC_CODIV_LO] <
             ctc_pkg::CTC_CODIV_MIN) begin
            co_lim = ctc_pkg::CTC_CODIV_MIN - 4'h1;
         end else begin
            co_lim = cfg_q[ctc_pkg::CTC_CODIV_HI:ctc_pkg::CTC_CODIV_LO]
               - 4'h1;
         end
      end
   end

   // Counter is not cleared on a source change, so a pulse may be cut short
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         co_cnt_q <= 4'h0;
         clkout_en <= 1'b0;
      end else begin
         clkout_en <= 1'b0;
         if (co_src) begin
            if (co_cnt_q >= co_lim) begin
               co_cnt_q <= 4'h0;
               clkout_en <= 1'b1;
            end else begin
               co_cnt_q <= co_cnt_q + 4'h1;
            end
         end
      end
   end

   // Main bus prescaler, divides system clock (mclk)
   always_comb begin
      mb_lim = 4'h0;
      if (cfg_q[ctc_pkg::CTC_MBP_HI]) begin
         mb_lim = 4'((5'h2 << cfg_q[ctc_pkg::CTC_MBP_LO +: 2])
            - 5'h1);
      end
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mb_cnt_q <= 4'h0;
      end else if (mb_cnt_q >= mb_lim) begin
         mb_cnt_q <= 4'h0;
      end else begin
         mb_cnt_q <= mb_cnt_q + 4'h1;
      end
   end
   assign mb_tick = (mb_cnt_q >= mb_lim);
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         main_bus_en <= 1'b0;
      end else begin
         main_bus_en <= mb_tick;
      end
   end

   // Peripheral prescalers, 0 = fast, 1 = slow
   generate
      for (genvar i = 0; i < 2; i++) begin : g_pp
         logic [2:0] code;
         assign code = (i == 0) ?
            cfg_q[ctc_pkg::CTC_FPP_HI:ctc_pkg::CTC_FPP_LO] :
            cfg_q[ctc_pkg::CTC_SPP_HI:ctc_pkg::CTC_SPP_LO];
         always_comb begin
            pp_lim[i] = 4'h0;
            if (code[2]) begin
               pp_lim[i] = 4'((5'h2 << code[1:0])
                  - 5'h1);
            end
         end
         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               pp_cnt_q[i] <= 4'h0;
            end else if (mb_tick) begin
               if (pp_cnt_q[i] >= pp_lim[i]) begin
                  pp_cnt_q[i] <= 4'h0;
               end else begin
                  pp_cnt_q[i] <= pp_cnt_q[i] + 4'h1;
               end
            end
         end
         assign pp_tick[i] = mb_tick && (pp_cnt_q[i] >= pp_lim[i]);
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fast_periph_en <= 1'b0;
         slow_periph_en <= 1'b0;
      end else begin
         fast_periph_en <= pp_tick[0];
         slow_periph_en <= pp_tick[1];
      end
   end

   // Registered copies of configuration for the system clock switch and the analog loop
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         system_clock_switch <= 3'h0;
         loop_source_sel <= 1'b0;
         loop_multiplier <= ctc_pkg::CTC_LMUL_OFFSET;
         loop_input_prescaler <= 2'h0;
      end else begin
         system_clock_switch <= cfg_q[ctc_pkg::CTC_SW_HI:ctc_pkg::CTC_SW_LO];
         loop_source_sel <= cfg_q[ctc_pkg::CTC_LSRC_BIT];
         loop_multiplier <= {1'b0, cfg_q[ctc_pkg::CTC_LMUL_HI:
            ctc_pkg::CTC_LMUL_LO]} + ctc_pkg::CTC_LMUL_OFFSET;
         loop_input_prescaler <=
            cfg_q[ctc_pkg::CTC_LPRE_HI:ctc_pkg::CTC_LPRE_LO];
      end
   end
endmodule : ctc_clock_config

// ===== dv/ctc_monitor.sv
// Assertion checker for the clock tree configuration block
`timescale 1ns/1ps
module ctc_monitor (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire ctc_pkg::ctc_bus_t bus,
   input wire logic [31:0] rdata,
   input wire ctc_pkg::ctc_src_t src,
   input wire logic [2:0] active_source,
   input wire logic stop_exit,
   input wire logic fast_ext_fail,
   input wire logic clock_security_enable,
   input wire logic [2:0] system_clock_switch,
   input wire logic loop_source_sel,
   input wire logic [4:0] loop_multiplier,
   input wire logic loop_in_en,
   input wire logic loop_out_en
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence cfg_rd_s;
      $past(bus.rd) && $past(bus.addr) == ctc_pkg::CTC_CFG_ADDR;
   endsequence
   idle_zero_a: assert property (!$past(bus.rd) |-> rdata == 32'h0)
      else $error("read data not zero outside a read");
   mul_read_a: assert property (cfg_rd_s |->
      loop_multiplier == {1'b0, rdata[19:16]} + 5'h03)
      else $error("multiplier port differs from field plus three");
   mul_range_a: assert property (
      loop_multiplier >= 5'h03 && loop_multiplier <= 5'h12)
      else $error("multiplier out of range");
   fld_read_a: assert property (cfg_rd_s |->
      loop_source_sel == rdata[24] && system_clock_switch == rdata[2:0])
      else $error("field ports differ from register");
   stat_read_a: assert property (cfg_rd_s ##0
      ($stable(active_source) && $past(active_source, 2) == active_source)
      |-> {rdata[15:14], rdata[3]} == active_source)
      else $error("status code differs from active source");
   stop_force_a: assert property (stop_exit |->
      ##[1:2] system_clock_switch == 3'h0)
      else $error("switch not forced after stop exit");
   fail_force_a: assert property (
      fast_ext_fail && clock_security_enable |-> ##[1:2] system_clock_switch == 3'h0)
      else $error("switch not forced after oscillator failure");
   lin_src_a: assert property (
      loop_in_en && loop_source_sel |-> $past(src.fast_external_osc))
      else $error("loop input tick without external source tick");
   lout_src_a: assert property (loop_out_en |-> $past(src.loop))
      else $error("loop output tick without loop tick");
   cover property (stop_exit);
   cover property (cfg_rd_s);
   cover property (loop_out_en);
endmodule : ctc_monitor
bind ctc_clock_config ctc_monitor i_mon (.mclk, .sys_rst, .bus, .rdata,
   .src, .active_source, .stop_exit, .fast_ext_fail, .clock_security_enable,
   .system_clock_switch, .loop_source_sel, .loop_multiplier, .loop_in_en,
   .loop_out_en);

// ===== dv/tb.sv
// Self-checking testbench for the clock tree configuration block
`timescale 1ns/1ps
module tb;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   ctc_pkg::ctc_bus_t bus = '0;
   ctc_pkg::ctc_src_t src = '0;
   logic [2:0] act = 3'h0;
   logic stop_exit = 1'b0;
   logic fail = 1'b0;
   logic sec = 1'b0;
   logic [31:0] rdata;
   logic [2:0] sw;
   logic lsel;
   logic [4:0] lmul;
   logic [1:0] lpre;
   wire [5:0] en;
   logic [3:0] tcnt = 4'h0;
   int error_cnt = 0;
   int checks_done = 0;
   initial forever #2 mclk = ~mclk;
   ctc_clock_config i_dut (.mclk, .sys_rst, .bus, .rdata, .src,
      .active_source(act), .stop_exit, .fast_ext_fail(fail),
      .clock_security_enable(sec), .system_clock_switch(sw),
      .loop_source_sel(lsel), .loop_multiplier(lmul),
      .loop_input_prescaler(lpre), .loop_in_en(en[0]),
      .loop_out_en(en[1]), .clkout_en(en[2]), .main_bus_en(en[3]),
      .fast_periph_en(en[4]), .slow_periph_en(en[5]));
   // Distinct oscillator rates so a wrong route shows as a wrong count; loop ticks at the fast external rate
   always @(posedge mclk) begin
      tcnt <= (tcnt == 4'hb) ? 4'h0 : tcnt + 4'h1;
      src <= '{tcnt[1:0] == 2'h0, tcnt % 4'h3 == 4'h0, 1'b1, !tcnt[0],
         tcnt[0]};
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge mclk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(string n, logic [7:0] a, logic [31:0] e);
      @(posedge mclk);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      @(negedge mclk);
      chk(n, e, rdata);
   endtask : rd
   task automatic pulse(logic [1:0] v);
      @(posedge mclk);
      {stop_exit, fail} <= v;
      @(posedge mclk);
      {stop_exit, fail} <= 2'b00;
   endtask : pulse
   // Settle covers the longest period, so no cut pulse lands in the window
   task automatic sweep(string n, int i, int sh, logic [31:0] base,
      int c[6], int e[6]);
      int k;
      logic [31:0] cnt;
      for (k = 0; k < 6; k++) begin
         wr(8'h04, base | (c[k] << sh));
         repeat (24) @(posedge mclk);
         cnt = 0;
         repeat (48) begin
            @(negedge mclk);
            cnt = cnt + 32'(en[i]);
         end
         chk(n, e[k], cnt);
      end
   endtask : sweep
   task t_reset;
      rd("cfg", 8'h04, 32'h2000_0000);
      chk("mul", 32'h3, lmul);
      rd("ctrl", 8'h00, 32'h0);
      rd("unmapped", 8'h08, 32'h0);
   endtask : t_reset
   task t_rw;
      wr(8'h04, 32'hffff_ffff);
      rd("cfg", 8'h04, 32'hffff_3ff7);
      chk("mul", 32'h12, lmul);
      chk("lsel", 32'h1, lsel);
      chk("lpre", 32'h3, lpre);
   endtask : t_rw
   task t_lock;
      wr(8'h00, 32'h1);
      rd("ctrl_on", 8'h00, 32'h1);
      wr(8'h04, 32'h0);
      rd("locked", 8'h04, 32'h010f_0000);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      rd("unlocked", 8'h04, 32'h0);
   endtask : t_lock
   task t_stat;
      int s;
      for (s = 0; s < 5; s++) begin
         @(posedge mclk);
         act <= 3'(s);
         repeat (3) @(posedge mclk);
         rd("status", 8'h04,
            {16'h0, act[2:1], 10'h0, act[0], 3'h0});
      end
      @(posedge mclk);
      act <= 3'h0;
   endtask : t_stat
   task t_force;
      wr(8'h04, 32'h2);
      pulse(2'b10);
      rd("stop", 8'h04, 32'h0);
      wr(8'h04, 32'h2);
      pulse(2'b01);
      rd("nosec", 8'h04, 32'h2);
      @(posedge mclk);
      sec <= 1'b1;
      pulse(2'b01);
      rd("fail", 8'h04, 32'h0);
      chk("sw", 32'h0, sw);
      // Force and software write on one edge: the force must win
      @(posedge mclk);
      bus <= '{8'h04, 32'h2, 1'b1, 1'b0};
      stop_exit <= 1'b1;
      @(posedge mclk);
      bus.wr <= 1'b0;
      stop_exit <= 1'b0;
      rd("wrforce", 8'h04, 32'h0);
      @(posedge mclk);
      sec <= 1'b0;
   endtask : t_force
   task t_div;
      // Source ticks are abstract rates; every programmed setting is legal
      sweep("main", 3, 4, 0, '{0,7,8,9,10,11},
         '{48,48,24,12,6,3});
      sweep("fast", 4, 11, 0, '{0,3,4,5,6,7},
         '{48,48,24,12,6,3});
      sweep("slow", 5, 8, 0, '{0,3,4,5,6,7},
         '{48,48,24,12,6,3});
      sweep("lout", 1, 22, 0, '{0,1,2,3,0,3},
         '{24,12,8,6,24,6});
      sweep("lin", 0, 20, 0, '{0,1,2,3,16,17},
         '{48,24,16,12,24,12});
      sweep("cosel", 2, 25, 32'h2000_0000, '{0,1,2,3,4,5},
         '{0,12,16,48,48,24});
      sweep("codiv", 2, 28, 32'h0c00_0000, '{0,2,3,4,12,2},
         '{12,12,8,6,2,12});
   endtask : t_div
   task end_of_test;
      $display("mismatches %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   initial begin
      #100000;
      error_cnt++;
      end_of_test;
   end
   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset;
      t_rw;
      t_lock;
      t_stat;
      t_force;
      t_div;
      end_of_test;
   end
endmodule : tb
